// file: hw/rotate_instruction_unit.sv
// Rotate datapath with opcode decode, working registers, data memory
// and flags, reached over an APB slave.
// Assumes one 50 MHz clock shared with the APB master.
//
// Our own choices: register access over APB and the register offsets.
`default_nettype none
`include "rotate_unit_defs.svh"

module rotate_instruction_unit #(
  parameter int DMEM_DEPTH = 256
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);

  localparam int IW = $clog2(DMEM_DEPTH);

  logic [15:0]                  w_q [16];
  logic [15:0]                  dmem [DMEM_DEPTH];
  logic [23:0]                  instr_q;
  logic                         n_q, z_q, c_q, ill_q;
  logic [31:0]                  prdata_q;
  logic                         rd_done_q;
  logic                         access, wr_acc, rd_go;
  logic                         hit_instr, hit_status, hit_work, hit_dmem, mapped;
  logic [11:0]                  dofs;
  logic [23:0]                  op;
  rotate_unit_pkg::op_kind_t    kind;
  logic                         wform, legal, exec, byte_op, dsel;
  logic [2:0]                   dmode, smode;
  logic [3:0]                   target_work_register, source_work_register;
  logic [15:0]                  step, sp, s_next, s_ea, d_base, d_next, d_ea;
  logic [15:0]                  s_word, opnd, res, d_word;
  logic                         carry_d, neg_d, zero_d, to_mem;
  logic [31:0]                  rd_mux;

  // Merge 16-bit register data under the two low byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wdata,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? wdata[15:8] : old[15:8], strb[0] ? wdata[7:0] : old[7:0]};
  endfunction : merge16

  // APB decode; writes finish in the access cycle, reads wait one cycle
  assign access     = psel_i & penable_i;
  assign dofs       = paddr_i - `OFS_DMEM_BASE;
  assign hit_instr  = (paddr_i == `OFS_INSTR);
  assign hit_status = (paddr_i == `OFS_STATUS);
  assign hit_work   = ((paddr_i & `OFS_WORK_MASK) == `OFS_WORK_BASE);
  assign hit_dmem   = (paddr_i >= `OFS_DMEM_BASE) && (dofs[11:2] < 10'(DMEM_DEPTH));
  assign mapped     = hit_instr | hit_status | hit_work | hit_dmem;
  assign wr_acc     = access & pwrite_i;
  assign rd_go      = access & ~pwrite_i & ~rd_done_q;
  assign pready_o   = access & (pwrite_i | rd_done_q);
  assign pslverr_o  = pready_o & ~mapped;
  assign prdata_o   = prdata_q;

  // A write to the instruction register runs the rotate at that edge
  assign op   = pwdata_i[23:0];
  assign exec = wr_acc & hit_instr;

  // Opcode class decode
  always_comb begin
    kind  = rotate_unit_pkg::KIND_NONE;
    wform = 1'b0;
    if (op[`FLD_CLASS_HI:`FLD_CLASS_LO] == `OPC_WORK_LEFT && !op[`FLD_CARRY]) begin
      kind  = rotate_unit_pkg::KIND_ROTATE_LEFT_PLAIN;
      wform = 1'b1;
    end else if (op[`FLD_CLASS_HI:`FLD_CLASS_LO] == `OPC_WORK_RIGHT) begin
      kind  = op[`FLD_CARRY] ? rotate_unit_pkg::KIND_ROTATE_RIGHT_THROUGH_CARRY
                             : rotate_unit_pkg::KIND_ROTATE_RIGHT_PLAIN;
      wform = 1'b1;
    end else if (op[`FLD_CLASS_HI:`FLD_CLASS_LO] == `OPC_FILE_RIGHT) begin
      kind  = op[`FLD_CARRY] ? rotate_unit_pkg::KIND_ROTATE_RIGHT_THROUGH_CARRY
                             : rotate_unit_pkg::KIND_ROTATE_RIGHT_PLAIN;
    end
  end

  // Operand fields
  assign byte_op              = op[`FLD_BYTE];
  assign dsel                 = op[`FLD_DSEL];
  assign dmode                = op[`FLD_DMODE_HI:`FLD_DMODE_LO];
  assign target_work_register = op[`FLD_DREG_HI:`FLD_DREG_LO];
  assign smode                = op[`FLD_SMODE_HI:`FLD_SMODE_LO];
  assign source_work_register = op[`FLD_SREG_HI:0];
  // Modes 6 and 7 need an offset register this unit lacks, so they refuse
  assign legal = (kind != rotate_unit_pkg::KIND_NONE) &&
                 (!wform || (smode <= `MODE_PRE_INC && dmode <= `MODE_PRE_INC));
  assign step  = byte_op ? `STEP_BYTE : `STEP_WORD;

  // Source address and pointer update
  assign sp = w_q[source_work_register];
  always_comb begin
    case (smode)
      `MODE_POST_DEC, `MODE_PRE_DEC: s_next = sp - step;
      `MODE_POST_INC, `MODE_PRE_INC: s_next = sp + step;
      default:                       s_next = sp;
    endcase
    if (!wform) begin
      s_ea = {3'h0, op[`FLD_FADDR_HI:0]};
    end else if (smode == `MODE_PRE_DEC || smode == `MODE_PRE_INC) begin
      s_ea = s_next;
    end else begin
      s_ea = sp;
    end
  end

  // Target pointer sees the source update when both name one register
  assign d_base = (target_work_register == source_work_register) ? s_next
                                                                 : w_q[target_work_register];
  always_comb begin
    case (dmode)
      `MODE_POST_DEC, `MODE_PRE_DEC: d_next = d_base - step;
      `MODE_POST_INC, `MODE_PRE_INC: d_next = d_base + step;
      default:                       d_next = d_base;
    endcase
    if (!wform) begin
      d_ea = {3'h0, op[`FLD_FADDR_HI:0]};
    end else if (dmode == `MODE_PRE_DEC || dmode == `MODE_PRE_INC) begin
      d_ea = d_next;
    end else begin
      d_ea = d_base;
    end
  end

  // Operand fetch; byte addresses pick the lane with bit 0
  assign s_word = dmem[s_ea[IW:1]];
  assign d_word = dmem[d_ea[IW:1]];
  always_comb begin
    opnd = (wform && smode == `MODE_DIRECT) ? sp : s_word;
    if (byte_op && !(wform && smode == `MODE_DIRECT) && s_ea[0]) begin
      opnd = {8'h00, s_word[15:8]};
    end else if (byte_op) begin
      opnd = {8'h00, opnd[7:0]};
    end
  end

  // Rotate datapath, same mapping for file and working forms
  always_comb begin
    res     = 16'h0000;
    carry_d = c_q;
    case (kind)
      rotate_unit_pkg::KIND_ROTATE_LEFT_PLAIN: begin
        res = byte_op ? {8'h00, opnd[6:0], opnd[7]}
                      : {opnd[14:0], opnd[15]};
      end
      rotate_unit_pkg::KIND_ROTATE_RIGHT_THROUGH_CARRY: begin
        res     = byte_op ? {8'h00, c_q, opnd[7:1]} : {c_q, opnd[15:1]};
        carry_d = opnd[0];
      end
      rotate_unit_pkg::KIND_ROTATE_RIGHT_PLAIN: begin
        res = byte_op ? {8'h00, opnd[0], opnd[7:1]} : {opnd[0], opnd[15:1]};
      end
      default: res = 16'h0000;
    endcase
    neg_d  = byte_op ? res[7] : res[15];
    zero_d = byte_op ? (res[7:0] == 8'h00) : (res == 16'h0000);
  end

  // Result goes to memory for pointer targets or file form with select set
  assign to_mem = wform ? (dmode != `MODE_DIRECT) : dsel;

  // Working registers: APB writes, pointer updates and register results
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < 16; i++) begin
        w_q[i] <= 16'h0000;
      end
    end else if (wr_acc && hit_work) begin
      w_q[paddr_i[5:2]] <= merge16(w_q[paddr_i[5:2]], pwdata_i, pstrb_i);
    end else if (exec && legal && wform) begin
      w_q[source_work_register] <= s_next;
      if (dmode == `MODE_DIRECT) begin
        w_q[target_work_register] <= byte_op ? {d_base[15:8], res[7:0]} : res;
      end else begin
        w_q[target_work_register] <= d_next;
      end
    end else if (exec && legal && !dsel) begin
      // Byte result keeps the upper half of the default register
      w_q[0] <= byte_op ? {w_q[0][15:8], res[7:0]} : res;
    end
  end

  // Data memory: no reset, contents are software data
  always_ff @(posedge clk_i) begin
    if (wr_acc && hit_dmem) begin
      dmem[dofs[IW+1:2]] <= merge16(dmem[dofs[IW+1:2]], pwdata_i, pstrb_i);
    end else if (exec && legal && to_mem) begin
      if (!byte_op) begin
        dmem[d_ea[IW:1]] <= res;
      end else if (d_ea[0]) begin
        dmem[d_ea[IW:1]] <= {res[7:0], d_word[7:0]};
      end else begin
        dmem[d_ea[IW:1]] <= {d_word[15:8], res[7:0]};
      end
    end
  end

  // Flags; a refused opcode leaves them alone and raises the illegal bit
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      n_q   <= `STAT_RESET;
      z_q   <= `STAT_RESET;
      c_q   <= `STAT_RESET;
      ill_q <= `STAT_RESET;
    end else if (wr_acc && hit_status) begin
      n_q   <= pwdata_i[`STAT_N_BIT];
      z_q   <= pwdata_i[`STAT_Z_BIT];
      c_q   <= pwdata_i[`STAT_C_BIT];
      ill_q <= pwdata_i[`STAT_ILL_BIT];
    end else if (exec) begin
      ill_q <= ~legal;
      if (legal) begin
        n_q <= neg_d;
        z_q <= zero_d;
        c_q <= carry_d;
      end
    end
  end

  // Last instruction written, readable for debug
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      instr_q <= 24'h000000;
    end else if (exec) begin
      instr_q <= op;
    end
  end

  // Read multiplexer; unmapped reads return zero
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_instr) begin
      rd_mux = {8'h00, instr_q};
    end else if (hit_status) begin
      rd_mux[`STAT_N_BIT]   = n_q;
      rd_mux[`STAT_Z_BIT]   = z_q;
      rd_mux[`STAT_C_BIT]   = c_q;
      rd_mux[`STAT_ILL_BIT] = ill_q;
    end else if (hit_work) begin
      rd_mux = {16'h0000, w_q[paddr_i[5:2]]};
    end else if (hit_dmem) begin
      rd_mux = {16'h0000, dmem[dofs[IW+1:2]]};
    end
  end

  // Read data registered one cycle into the access phase
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_q  <= 32'h00000000;
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= rd_go;
      if (rd_go) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // Checks on the datapath, flags and APB write timing
  rotl_word_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && kind == rotate_unit_pkg::KIND_ROTATE_LEFT_PLAIN && !byte_op
      |-> {res[0], res[15:1]} == opnd)
    else $error("word left rotate mapping wrong");

  rotl_byte_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && kind == rotate_unit_pkg::KIND_ROTATE_LEFT_PLAIN && byte_op
      |-> {res[0], res[7:1]} == opnd[7:0] && res[15:8] == 8'h00)
    else $error("byte left rotate mapping wrong");

  thru_carry_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && legal && kind == rotate_unit_pkg::KIND_ROTATE_RIGHT_THROUGH_CARRY
      |=> c_q == $past(opnd[0]) && $past(byte_op ? res[7] : res[15]) == $past(c_q))
    else $error("carry rotate did not pass carry through");

  plain_carry_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && legal && kind != rotate_unit_pkg::KIND_ROTATE_RIGHT_THROUGH_CARRY
      |=> $stable(c_q))
    else $error("plain rotate changed carry");

  zero_flag_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && legal |=> z_q == ($past(byte_op) ? ($past(res[7:0]) == 8'h00)
                                            : ($past(res) == 16'h0000)))
    else $error("zero flag does not match result");

  default_reg_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && legal && !wform && !dsel && !byte_op |=> w_q[0] == $past(res))
    else $error("default register not written");

  ptr_step_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && legal && wform && smode == `MODE_POST_INC &&
    source_work_register != target_work_register
      |=> w_q[$past(source_work_register)] == $past(sp) + ($past(byte_op) ? 16'h0001
                                                                          : 16'h0002))
    else $error("pointer step wrong");

  one_cycle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    access && pwrite_i |-> pready_o)
    else $error("instruction write stalled");

  refused_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && !legal |=> ill_q && $stable(n_q) && $stable(z_q) && $stable(c_q))
    else $error("refused opcode changed flags");

  neg_flag_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && legal |=> n_q == ($past(byte_op) ? $past(res[7]) : $past(res[15])))
    else $error("negative flag does not match result");

  // Select bit set sends the word back to memory and spares the default register
  file_back_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    exec && legal && !wform && dsel && !byte_op
      |=> dmem[$past(d_ea[IW:1])] == $past(res) && $stable(w_q[0]))
    else $error("file result not written back");

endmodule : rotate_instruction_unit

`default_nettype wire

// file: hw/rotate_unit_defs.svh
// Constants of the rotate unit: register offsets, status bit places,
// opcode fields and addressing-mode codes.
// Assumes a 12-bit APB byte address and 24-bit instruction words.
`ifndef ROTATE_UNIT_DEFS_SVH
`define ROTATE_UNIT_DEFS_SVH

// Register map, byte addresses
`define OFS_INSTR      12'h000
`define OFS_STATUS     12'h004
`define OFS_WORK_BASE  12'h040
`define OFS_WORK_MASK  12'hFC0
`define OFS_DMEM_BASE  12'h800

// Status bit places and reset value
`define STAT_C_BIT     0
`define STAT_Z_BIT     1
`define STAT_N_BIT     3
`define STAT_ILL_BIT   8
`define STAT_RESET     1'b0

// Opcode class byte, bits 23:16
`define OPC_WORK_LEFT  8'hD2
`define OPC_WORK_RIGHT 8'hD3
`define OPC_FILE_RIGHT 8'hD7

// Opcode field places
`define FLD_CLASS_HI   23
`define FLD_CLASS_LO   16
`define FLD_CARRY      15
`define FLD_BYTE       14
`define FLD_DSEL       13
`define FLD_FADDR_HI   12
`define FLD_DMODE_HI   13
`define FLD_DMODE_LO   11
`define FLD_DREG_HI    10
`define FLD_DREG_LO    7
`define FLD_SMODE_HI   6
`define FLD_SMODE_LO   4
`define FLD_SREG_HI    3

// Addressing modes of the three-bit mode fields
`define MODE_DIRECT    3'h0
`define MODE_INDIRECT  3'h1
`define MODE_POST_DEC  3'h2
`define MODE_POST_INC  3'h3
`define MODE_PRE_DEC   3'h4
`define MODE_PRE_INC   3'h5

// Pointer steps for byte and word operands
`define STEP_BYTE      16'h0001
`define STEP_WORD      16'h0002

`endif

// file: hw/rotate_unit_pkg.sv
// Types shared by the rotate unit.
// Assumes nothing of its surroundings.
`default_nettype none

package rotate_unit_pkg;

  // Which rotate an opcode asks for
  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_ROTATE_LEFT_PLAIN,
    KIND_ROTATE_RIGHT_THROUGH_CARRY,
    KIND_ROTATE_RIGHT_PLAIN
  } op_kind_t;

endpackage : rotate_unit_pkg

`default_nettype wire

// file: verif/rotate_instruction_unit_bench.sv
// Self-checking bench of the rotate unit: APB tasks and opcode runs.
// Assumes no wait state on writes and one on reads; memory is loaded first.
`default_nettype none
`include "rotate_unit_defs.svh"

module rotate_instruction_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i     = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [11:0] paddr_i   = 12'h000;
  logic [31:0] pwdata_i  = 32'h00000000;
  logic [3:0]  pstrb_i   = 4'hF;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  int          failures  = 0;
  int          n_checks  = 0;
  int          cycles    = 0;
  int          waits;
  logic [31:0] rd;
  logic        err;

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  rotate_instruction_unit #(.DMEM_DEPTH(256)) i_rotate_instruction_unit (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .pstrb_i   (pstrb_i),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o)
  );

  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      complete_run();
    end
  end

  task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_bit

  // One APB transfer; pready, data and error are taken at the rising edge,
  // read just after it, before any flop of the slave has updated
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    waits = 0;
    @(posedge clk_i);
    while (pready_o !== 1'b1) begin
      waits++;
      @(posedge clk_i);
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : xfer

  task automatic put(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    chk_bit("write error", 1'b0, err);
  endtask : put

  task automatic get(input string nm, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    chk_word(nm, exp, rd);
    chk_bit("read error", 1'b0, err);
  endtask : get

  function automatic logic [11:0] wa(input logic [3:0] n);
    return `OFS_WORK_BASE + {6'h00, n, 2'h0};
  endfunction : wa

  function automatic logic [11:0] ma(input logic [7:0] i);
    return `OFS_DMEM_BASE + {2'h0, i, 2'h0};
  endfunction : ma

  // Working-register form opcode
  function automatic logic [31:0] wop(input logic [7:0] cls, input logic cb, input logic bb,
                                      input logic [2:0] dm, input logic [3:0] dr,
                                      input logic [2:0] sm, input logic [3:0] sr);
    return {8'h00, cls, cb, bb, dm, dr, sm, sr};
  endfunction : wop

  // File form opcode
  function automatic logic [31:0] fop(input logic cb, input logic bb, input logic ds,
                                      input logic [12:0] f);
    return {8'h00, `OPC_FILE_RIGHT, cb, bb, ds, f};
  endfunction : fop

  // Execution must finish with no wait state and no bus error
  task automatic exec(input logic [31:0] op);
    xfer(1'b1, `OFS_INSTR, op);
    chk_word("exec waits", 32'h00000000, 32'(waits));
    chk_bit("exec error", 1'b0, err);
  endtask : exec

  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    get("status reset", `OFS_STATUS, 32'h00000000);
    get("W5 reset", wa(4'h5), 32'h00000000);
    // Plain left rotates; carry set beforehand must survive
    put(`OFS_STATUS, 32'h00000001);
    put(wa(4'h1), 32'h00008001);
    exec(wop(`OPC_WORK_LEFT, 1'b0, 1'b0, 3'h0, 4'h3, 3'h0, 4'h1));
    get("W3 left word", wa(4'h3), 32'h00000003);
    get("status left word", `OFS_STATUS, 32'h00000001);
    put(wa(4'h0), 32'h00009976);
    put(wa(4'h3), 32'h00005879);
    exec(wop(`OPC_WORK_LEFT, 1'b0, 1'b1, 3'h0, 4'h3, 3'h0, 4'h0));
    get("W3 left byte", wa(4'h3), 32'h000058EC);
    get("status left byte", `OFS_STATUS, 32'h00000009);
    // Right rotates through carry, word then byte to zero
    put(wa(4'h1), 32'h0000216E);
    exec(wop(`OPC_WORK_RIGHT, 1'b1, 1'b0, 3'h0, 4'h5, 3'h0, 4'h1));
    get("W5 carry right word", wa(4'h5), 32'h000090B7);
    get("status carry right word", `OFS_STATUS, 32'h00000008);
    put(wa(4'h1), 32'h00000001);
    put(wa(4'h4), 32'h0000AB00);
    exec(wop(`OPC_WORK_RIGHT, 1'b1, 1'b1, 3'h0, 4'h4, 3'h0, 4'h1));
    get("W4 carry right byte", wa(4'h4), 32'h0000AB00);
    get("status carry right byte", `OFS_STATUS, 32'h00000003);
    // Plain right rotates keep the carry just set
    put(wa(4'h1), 32'h0000216E);
    exec(wop(`OPC_WORK_RIGHT, 1'b0, 1'b0, 3'h0, 4'h6, 3'h0, 4'h1));
    get("W6 plain right word", wa(4'h6), 32'h000010B7);
    put(wa(4'h3), 32'h00005879);
    exec(wop(`OPC_WORK_RIGHT, 1'b0, 1'b1, 3'h0, 4'h3, 3'h0, 4'h0));
    get("W3 plain right byte", wa(4'h3), 32'h0000583B);
    get("status plain right", `OFS_STATUS, 32'h00000001);
    // File forms: to the default register, then back to memory
    put(ma(8'h10), 32'h0000216E);
    exec(fop(1'b1, 1'b0, 1'b0, 13'h0020));
    get("W0 file carry right", wa(4'h0), 32'h000090B7);
    get("mem kept", ma(8'h10), 32'h0000216E);
    exec(fop(1'b0, 1'b0, 1'b1, 13'h0020));
    get("mem plain right", ma(8'h10), 32'h000010B7);
    exec(fop(1'b0, 1'b1, 1'b1, 13'h0021));
    get("mem upper byte", ma(8'h10), 32'h000008B7);
    // Pointer modes and their steps
    put(wa(4'h2), 32'h00000008);
    put(ma(8'h04), 32'h0000C041);
    put(wa(4'h8), 32'h0000004E);
    exec(wop(`OPC_WORK_LEFT, 1'b0, 1'b0, `MODE_INDIRECT, 4'h8, `MODE_POST_INC, 4'h2));
    get("mem at W8", ma(8'h27), 32'h00008083);
    get("W2 post inc", wa(4'h2), 32'h0000000A);
    get("status pointer", `OFS_STATUS, 32'h00000008);
    put(wa(4'h2), 32'h0000000B);
    put(ma(8'h05), 32'h00001280);
    put(wa(4'h9), 32'h0000FF00);
    exec(wop(`OPC_WORK_LEFT, 1'b0, 1'b1, `MODE_DIRECT, 4'h9, `MODE_PRE_DEC, 4'h2));
    get("W9 byte pre dec", wa(4'h9), 32'h0000FF01);
    get("W2 pre dec", wa(4'h2), 32'h0000000A);
    put(wa(4'hA), 32'h00000010);
    exec(wop(`OPC_WORK_RIGHT, 1'b0, 1'b0, `MODE_PRE_INC, 4'hA, `MODE_DIRECT, 4'h1));
    get("mem pre inc", ma(8'h09), 32'h000010B7);
    get("W10 pre inc", wa(4'hA), 32'h00000012);
    // Post-decrement target writes at the old pointer, then steps down by two
    put(wa(4'hB), 32'h00000020);
    exec(wop(`OPC_WORK_RIGHT, 1'b0, 1'b0, `MODE_POST_DEC, 4'hB, `MODE_DIRECT, 4'h1));
    get("mem post dec", ma(8'h10), 32'h000010B7);
    get("W11 post dec", wa(4'hB), 32'h0000001E);
    // Illegal codes change nothing but the illegal flag and the opcode readback
    xfer(1'b1, `OFS_INSTR, wop(`OPC_WORK_LEFT, 1'b1, 1'b0, 3'h0, 4'h3, 3'h0, 4'h1));
    chk_bit("illegal error", 1'b0, err);
    xfer(1'b1, `OFS_INSTR, wop(`OPC_WORK_RIGHT, 1'b0, 1'b0, 3'h0, 4'h3, 3'h6, 4'h1));
    get("status mode six", `OFS_STATUS, 32'h00000100);
    xfer(1'b1, `OFS_INSTR, {8'h00, 8'hD6, 16'h2020});
    get("W3 kept", wa(4'h3), 32'h0000583B);
    get("status illegal", `OFS_STATUS, 32'h00000100);
    get("opcode readback", `OFS_INSTR, 32'h00D62020);
    // Unmapped place answers with an error and zero data
    xfer(1'b0, 12'h020, 32'h00000000);
    chk_word("unmapped data", 32'h00000000, rd);
    chk_bit("unmapped read", 1'b1, err);
    xfer(1'b1, 12'h020, 32'hFFFFFFFF);
    chk_bit("unmapped write", 1'b1, err);
    complete_run();
  end

endmodule : rotate_instruction_unit_bench

`default_nettype wire
